// >>> hw/scsq_consts.vh
// constants for the sampling clock select and qualify block
`ifndef SCSQ_CONSTS_VH
`define SCSQ_CONSTS_VH

// ----------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------
`define SCSQ_IDX_CTRL    5'h00
`define SCSQ_IDX_PERIOD  5'h01
`define SCSQ_IDX_DELAY   5'h02
`define SCSQ_IDX_SEQ     5'h03
`define SCSQ_IDX_QUAL    5'h04
`define SCSQ_IDX_STATUS  5'h05
`define SCSQ_IDX_RATIO   5'h06
`define SCSQ_IDX_RTLO    5'h07
`define SCSQ_IDX_RTHI    5'h08
`define SCSQ_IDX_COUNT   5'h09
`define SCSQ_IDX_CMD     5'h0a
`define SCSQ_IDX_TVAL    5'h10
`define SCSQ_IDX_TCARE   5'h14

// ----------------------------------------
// reset values and field codes
// ----------------------------------------
`define SCSQ_CTRL_RST    32'h0000003a
`define SCSQ_PERIOD_RST  32'h0000000a
`define SCSQ_SRC_INT     1'b0
`define SCSQ_SRC_EXT     1'b1
`define SCSQ_QUAL_LOW    2'h0
`define SCSQ_QUAL_HIGH   2'h1
`define SCSQ_QUAL_ALWAYS 2'h2
`define SCSQ_DQ_OFF      2'h0
`define SCSQ_DQ_COMB     2'h1
`define SCSQ_DQ_STATE    2'h2
`define SCSQ_W32         2'h3
`define SCSQ_UNIT_NS     2'h0
`define SCSQ_UNIT_US     2'h1
`define SCSQ_SEQ_USER    5'h13

// ----------------------------------------
// timing: reference period 5 ns, limits 10 ns and 200 ms
// ----------------------------------------
`define SCSQ_REF_NS      32'h00000005
`define SCSQ_MIN_NS      32'h0000000a
`define SCSQ_MAX_MS      32'h000000c8
`define SCSQ_US_CYC      32'h000000c8
`define SCSQ_MS_CYC      32'h00030d40
`define SCSQ_MIN_RATIO   (`SCSQ_MIN_NS / `SCSQ_REF_NS)
`define SCSQ_MAX_RATIO   (`SCSQ_MAX_MS * `SCSQ_MS_CYC)
`define SCSQ_TAIL        5'h11
`define SCSQ_DEPTH4      40'h0000001f40
`define SCSQ_DEPTH8      40'h0000000fa0
`define SCSQ_DEPTH16     40'h00000007d0
`define SCSQ_DEPTH32     40'h00000003e8
`define SCSQ_RSP_OK      2'h0
`define SCSQ_RSP_ERR     2'h2

`endif

// >>> hw/scsq_top.v
// sampling clock selection, qualification and record control
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "scsq_consts.vh"

module scsq_top (
    input  wire        CLOCK,
    input  wire        RSTN,
    input  wire [6:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg  [1:0]  AVS_RESPONSE,
    output reg         AVS_WAITREQUEST,
    input  wire        EXT_CLK,
    input  wire        EXT_QUAL,
    input  wire [31:0] PROBE,
    output reg         SAMPLE_VALID,
    output reg  [31:0] SAMPLE_DATA,
    output reg         ACTIVE,
    output reg         TRIGGERED
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // byte-lane merge of a write into an old value
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer i;
        begin
            be_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) be_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // masked compare: cleared care bits always match
    function word_hit;
        input [31:0] d;
        input [31:0] v;
        input [31:0] c;
        begin
            word_hit = (((d ^ v) & c) == 32'h00000000);
        end
    endfunction

    // period to divide ratio, clamped to what the divider can make
    function [31:0] calc_ratio;
        input [31:0] per;
        reg   [31:0] r;
        begin
            case (per[17:16])
                `SCSQ_UNIT_NS: r = ({18'h00000, per[13:0]} + 32'h00000002) / `SCSQ_REF_NS;
                `SCSQ_UNIT_US: r = {18'h00000, per[13:0]} * `SCSQ_US_CYC;
                default:       r = {18'h00000, per[13:0]} * `SCSQ_MS_CYC;
            endcase
            if (r < `SCSQ_MIN_RATIO) r = `SCSQ_MIN_RATIO;
            if (r > `SCSQ_MAX_RATIO) r = `SCSQ_MAX_RATIO;
            calc_ratio = r;
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [31:0] ctrl_q;          // source, edge, qualifier, width, dq type
    reg [31:0] period_q;        // [13:0] value, [17:16] unit
    reg [16:0] delay_q;         // trigger delay in samples
    reg [4:0]  seq_q;           // sequence code
    reg [15:0] qual_q;          // data qualification words
    reg [31:0] tval_q [0:3];    // trigger word values
    reg [31:0] tcare_q [0:3];   // trigger word care masks
    reg [31:0] ratio_q;         // derived divide ratio
    reg [39:0] rtime_q;         // derived record time in ref cycles
    reg [31:0] div_q;           // internal divider count
    reg        clk_s1_q;        // external clock sync stages
    reg        clk_s2_q;
    reg        clk_s3_q;
    reg        qual_s1_q;       // qualifier sync stages
    reg        qual_s2_q;
    reg [31:0] probe_s1_q;      // probe data sync stages
    reg [31:0] probe_s2_q;
    reg [1:0]  stage_q;         // sequence position
    reg [16:0] dcnt_q;          // delay progress
    reg        dly_done_q;      // delay satisfied, tail running
    reg [4:0]  tail_q;          // internal tail clocks consumed
    reg        rec_en_q;        // state qualification enable
    reg        done_q;          // recording has ended
    reg [31:0] count_q;         // samples delivered
    reg [31:0] rdata_d;         // read mux
    reg        hit_idx;         // address decodes to a register
    integer    k;

    // ----------------------------------------
    // decode of settings
    // ----------------------------------------
    wire       src_ext  = ctrl_q[0];
    wire       edge_r   = ctrl_q[1];
    wire [1:0] qmode    = ctrl_q[3:2];
    wire [1:0] wcode    = ctrl_q[5:4];
    wire [1:0] dq_type  = ctrl_q[7:6];
    wire [4:0] idx      = AVS_ADDRESS[6:2];
    wire       req      = AVS_READ | AVS_WRITE;
    wire       commit   = AVS_WRITE & ~AVS_WAITREQUEST;
    // merged write images, cut back to each register's own width below
    wire [31:0] delay_wr = be_merge({15'h0000, delay_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] qual_wr  = be_merge({16'h0000, qual_q}, AVS_WRITEDATA, AVS_BYTEENABLE);

    // ----------------------------------------
    // sample enable generation
    // ----------------------------------------
    // divider wraps after ratio cycles: one pulse per period
    wire int_tick = (div_q >= ratio_q - 32'h00000001);
    wire ext_rise = clk_s2_q & ~clk_s3_q;
    wire ext_fall = ~clk_s2_q & clk_s3_q;
    wire ext_edge = edge_r ? ext_rise : ext_fall;
    // qualifier is read at the same sync depth as the clock edge
    wire qual_ok  = (qmode == `SCSQ_QUAL_LOW)  ? ~qual_s2_q :
                    (qmode == `SCSQ_QUAL_HIGH) ?  qual_s2_q : 1'b1;
    wire ext_tick = ext_edge & qual_ok;
    wire tick     = src_ext ? ext_tick : int_tick;

    // ----------------------------------------
    // trigger word matching and qualification
    // ----------------------------------------
    wire [3:0] m;
    assign m[0] = word_hit(probe_s2_q, tval_q[0], tcare_q[0]);
    assign m[1] = word_hit(probe_s2_q, tval_q[1], tcare_q[1]);
    assign m[2] = word_hit(probe_s2_q, tval_q[2], tcare_q[2]);
    assign m[3] = word_hit(probe_s2_q, tval_q[3], tcare_q[3]);

    // index of the last ordered word the sequence needs
    wire [1:0] last_stage = (seq_q == `SCSQ_SEQ_USER) ? 2'h3 : seq_q[1:0];
    wire       occ_hit    = |(m & qual_q[7:4]);
    // qualification only exists at full width
    wire admit = (wcode != `SCSQ_W32 || dq_type == `SCSQ_DQ_OFF) ? 1'b1 :
                 (dq_type == `SCSQ_DQ_COMB) ? (occ_hit ^ qual_q[0]) :
                 rec_en_q;

    // width mask on delivered data
    wire [31:0] wmask = (wcode == 2'h0) ? 32'h0000000f :
                        (wcode == 2'h1) ? 32'h000000ff :
                        (wcode == 2'h2) ? 32'h0000ffff : 32'hffffffff;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // first stages feed only second stages, avoiding metastable enables
    always @(posedge CLOCK) begin
        clk_s1_q   <= EXT_CLK;
        clk_s2_q   <= clk_s1_q;
        clk_s3_q   <= clk_s2_q;
        qual_s1_q  <= EXT_QUAL;
        qual_s2_q  <= qual_s1_q;
        probe_s1_q <= PROBE;
        probe_s2_q <= probe_s1_q;
    end

    // ----------------------------------------
    // internal divider and derived figures
    // ----------------------------------------
    // ratio follows the period one cycle after it is written, record time one cycle after that
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            div_q   <= 32'h00000000;
            ratio_q <= 32'h00000002;
            rtime_q <= 40'h0000000000;
        end else begin
            div_q   <= int_tick ? 32'h00000000 : div_q + 32'h00000001;
            ratio_q <= calc_ratio(period_q);
            case (wcode)
                2'h0:    rtime_q <= {8'h00, ratio_q} * `SCSQ_DEPTH4;
                2'h1:    rtime_q <= {8'h00, ratio_q} * `SCSQ_DEPTH8;
                2'h2:    rtime_q <= {8'h00, ratio_q} * `SCSQ_DEPTH16;
                default: rtime_q <= {8'h00, ratio_q} * `SCSQ_DEPTH32;
            endcase
        end
    end

    // ----------------------------------------
    // bus slave: one wait cycle then answer
    // ----------------------------------------
    always @* begin
        hit_idx = 1'b1;
        rdata_d = 32'h00000000;
        case (idx)
            `SCSQ_IDX_CTRL:   rdata_d = ctrl_q;
            `SCSQ_IDX_PERIOD: rdata_d = period_q;
            `SCSQ_IDX_DELAY:  rdata_d = {15'h0000, delay_q};
            `SCSQ_IDX_SEQ:    rdata_d = {27'h0000000, seq_q};
            `SCSQ_IDX_QUAL:   rdata_d = {16'h0000, qual_q};
            `SCSQ_IDX_STATUS: rdata_d = {28'h0000000, rec_en_q, done_q, TRIGGERED, ACTIVE};
            `SCSQ_IDX_RATIO:  rdata_d = ratio_q;
            `SCSQ_IDX_RTLO:   rdata_d = rtime_q[31:0];
            `SCSQ_IDX_RTHI:   rdata_d = {24'h000000, rtime_q[39:32]};
            `SCSQ_IDX_COUNT:  rdata_d = count_q;
            `SCSQ_IDX_CMD:    rdata_d = 32'h00000000;
            default: begin
                // trigger words live at 0x10..0x17
                if (idx[4:3] == 2'h2) begin
                    rdata_d = idx[2] ? tcare_q[idx[1:0]] : tval_q[idx[1:0]];
                end else begin
                    hit_idx = 1'b0;
                end
            end
        endcase
    end

    // waitrequest drops for the edge at which the access completes
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
            AVS_RESPONSE    <= `SCSQ_RSP_OK;
        end else begin
            AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
            if (req & AVS_WAITREQUEST) begin
                AVS_READDATA <= AVS_READ ? rdata_d : 32'h00000000;
                AVS_RESPONSE <= hit_idx ? `SCSQ_RSP_OK : `SCSQ_RSP_ERR;
            end
        end
    end

    // ----------------------------------------
    // setting registers
    // ----------------------------------------
    // writes during recording are dropped; the command word stays open
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            ctrl_q   <= `SCSQ_CTRL_RST;
            period_q <= `SCSQ_PERIOD_RST;
            delay_q  <= 17'h00000;
            seq_q    <= 5'h00;
            qual_q   <= 16'h0000;
            for (k = 0; k < 4; k = k + 1) begin
                tval_q[k]  <= 32'h00000000;
                tcare_q[k] <= 32'h00000000;
            end
        end else if (commit && !ACTIVE) begin
            case (idx)
                `SCSQ_IDX_CTRL:   ctrl_q <= be_merge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE) &
                                            32'h000000ff;
                `SCSQ_IDX_PERIOD: period_q <= be_merge(period_q, AVS_WRITEDATA,
                                                       AVS_BYTEENABLE) & 32'h00033fff;
                `SCSQ_IDX_DELAY:  delay_q <= delay_wr[16:0];
                `SCSQ_IDX_SEQ: begin
                    // codes past the user sequence fall back to user defined
                    if (AVS_BYTEENABLE[0])
                        seq_q <= (AVS_WRITEDATA[4:0] > `SCSQ_SEQ_USER) ?
                                 `SCSQ_SEQ_USER : AVS_WRITEDATA[4:0];
                end
                `SCSQ_IDX_QUAL:   qual_q  <= qual_wr[15:0] & 16'hfff1;
                default: begin
                    if (idx[4:3] == 2'h2) begin
                        if (idx[2])
                            tcare_q[idx[1:0]] <= be_merge(tcare_q[idx[1:0]],
                                                          AVS_WRITEDATA, AVS_BYTEENABLE);
                        else
                            tval_q[idx[1:0]] <= be_merge(tval_q[idx[1:0]],
                                                         AVS_WRITEDATA, AVS_BYTEENABLE);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // recording engine
    // ----------------------------------------
    wire cmd_start = commit && idx == `SCSQ_IDX_CMD && AVS_BYTEENABLE[0] &&
                     AVS_WRITEDATA[0];
    wire cmd_stop  = commit && idx == `SCSQ_IDX_CMD && AVS_BYTEENABLE[0] &&
                     AVS_WRITEDATA[1];

    // the tail clocks are consumed but never delivered or counted, so
    // every reported position already excludes them
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            ACTIVE       <= 1'b0;
            TRIGGERED    <= 1'b0;
            SAMPLE_VALID <= 1'b0;
            SAMPLE_DATA  <= 32'h00000000;
            stage_q      <= 2'h0;
            dcnt_q       <= 17'h00000;
            dly_done_q   <= 1'b0;
            tail_q       <= 5'h00;
            rec_en_q     <= 1'b1;
            done_q       <= 1'b0;
            count_q      <= 32'h00000000;
        end else begin
            SAMPLE_VALID <= 1'b0;
            if (cmd_stop && ACTIVE) begin
                ACTIVE <= 1'b0;
                done_q <= 1'b1;
            end else if (cmd_start && !cmd_stop && !ACTIVE) begin
                // recording always opens with state enable set
                ACTIVE     <= 1'b1;
                TRIGGERED  <= 1'b0;
                stage_q    <= 2'h0;
                dcnt_q     <= 17'h00000;
                dly_done_q <= 1'b0;
                tail_q     <= 5'h00;
                rec_en_q   <= 1'b1;
                done_q     <= 1'b0;
                count_q    <= 32'h00000000;
            end else if (ACTIVE && tick) begin
                if (dly_done_q) begin
                    // internal tail: with the external source selected, the far side must keep clocking
                    if (tail_q == `SCSQ_TAIL - 5'h01) begin
                        ACTIVE <= 1'b0;
                        done_q <= 1'b1;
                    end
                    tail_q <= tail_q + 5'h01;
                end else begin
                    if (admit) begin
                        SAMPLE_VALID <= 1'b1;
                        SAMPLE_DATA  <= probe_s2_q & wmask;
                        count_q      <= count_q + 32'h00000001;
                    end
                    // state qualification: disable wins over reenable
                    if (|(m & qual_q[15:12]))
                        rec_en_q <= 1'b0;
                    else if (|(m & qual_q[11:8]))
                        rec_en_q <= 1'b1;
                    if (!TRIGGERED) begin
                        // words are recognised whether or not recorded
                        if (m[stage_q]) begin
                            if (stage_q == last_stage) begin
                                TRIGGERED <= 1'b1;
                                if (delay_q == 17'h00000)
                                    dly_done_q <= 1'b1;
                            end else begin
                                stage_q <= stage_q + 2'h1;
                            end
                        end
                    end else if (admit) begin
                        if (dcnt_q + 17'h00001 >= delay_q)
                            dly_done_q <= 1'b1;
                        dcnt_q <= dcnt_q + 17'h00001;
                    end
                end
            end
        end
    end

endmodule

// >>> bench/scsq_sut.sv
// partner model: system under test driving sampling clock, qualifier and probes
`timescale 1ns/1ps
module scsq_sut (
    output logic        ext_clk,
    output logic        ext_qual,
    output logic [31:0] probe
);
    // ----------------------------------------
    // free-running clock, 48 ns period
    // ----------------------------------------
    // rate stays well under the 70 MHz limit
    // runs without pause, so the tail clocks always arrive
    // qualifier and probes move only mid-phase, far from either edge
    initial begin
        ext_clk  = 1'b0;
        ext_qual = 1'b0;
        probe    = 32'h0;
        forever begin
            #12;
            probe[31:2] = probe[31:2] + 30'h1;  // running count marks each period
            ext_qual    = probe[3];             // qualifier toggles every two periods
            probe[1]    = probe[3];             // copy of qualifier level
            probe[0]    = 1'b1;                 // level seen by a rising edge
            #12 ext_clk = 1'b1;
            #12 probe[0] = 1'b0;                // level seen by a falling edge
            #12 ext_clk = 1'b0;
        end
    end
endmodule

// >>> bench/scsq_sva.sv
// assertion checker watching the ports of the sampling clock block
`timescale 1ns/1ps
module scsq_sva (
    input wire        CLOCK,
    input wire        RSTN,
    input wire [6:0]  AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire        AVS_WAITREQUEST,
    input wire        EXT_CLK,
    input wire        EXT_QUAL,
    input wire        SAMPLE_VALID,
    input wire [31:0] SAMPLE_DATA,
    input wire        ACTIVE,
    input wire        TRIGGERED
);
    reg [7:0] ctrl_q;  // shadow of the clock settings word
    reg [7:0] gap_q;   // cycles since the last delivered sample, saturating
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    // settings only change through an accepted write while idle
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            ctrl_q <= 8'h3a;
            gap_q  <= 8'h00;
        end else begin
            if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[6:2] == 5'h00 && !ACTIVE
                && AVS_BYTEENABLE[0]) begin
                ctrl_q <= AVS_WRITEDATA[7:0];
            end
            gap_q <= SAMPLE_VALID ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    wait_one_a: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus access not answered after one wait cycle");
    reset_state_a: assert property (
        $rose(RSTN) |-> AVS_WAITREQUEST && !ACTIVE && !TRIGGERED && !SAMPLE_VALID)
        else $error("outputs wrong right after reset");
    pulse_one_a: assert property (SAMPLE_VALID |=> !SAMPLE_VALID)
        else $error("sample pulse longer than one cycle");
    live_sample_a: assert property (SAMPLE_VALID |-> ACTIVE || $past(ACTIVE))
        else $error("sample delivered while not recording");
    trig_hold_a: assert property (!ACTIVE && !$past(ACTIVE) |-> $stable(TRIGGERED))
        else $error("trigger flag changed while idle");
    data_hold_a: assert property (!SAMPLE_VALID |-> $stable(SAMPLE_DATA))
        else $error("sample data changed without a sample");
    tail_gap_a: assert property ($fell(ACTIVE) && TRIGGERED |-> gap_q >= 8'h20)
        else $error("samples delivered during the tail clocks");
    qual_gate_a: assert property (
        SAMPLE_VALID && ctrl_q[0] && ctrl_q[3:2] != 2'h2 |-> $past(EXT_QUAL, 3) == ctrl_q[2])
        else $error("external edge taken while qualifier invalid");
    edge_pick_a: assert property (
        SAMPLE_VALID && ctrl_q[0] |-> $past(EXT_CLK, 2) == ctrl_q[1])
        else $error("sample taken on the wrong clock edge");
endmodule
bind scsq_top scsq_sva scsq_sva_i (
    .CLOCK(CLOCK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_CLK(EXT_CLK), .EXT_QUAL(EXT_QUAL),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA), .ACTIVE(ACTIVE),
    .TRIGGERED(TRIGGERED)
);

// >>> bench/test_scsq_top.sv
// self-checking bench for the sampling clock select and qualify block
`timescale 1ns/1ps
`include "scsq_consts.vh"
module test_scsq_top;
    logic        CLOCK, RSTN, AVS_READ, AVS_WRITE;
    logic [6:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, rd, wmask, ratio;
    logic [3:0]  AVS_BYTEENABLE;
    wire  [31:0] AVS_READDATA, PROBE, SAMPLE_DATA;
    wire  [1:0]  AVS_RESPONSE;
    wire         AVS_WAITREQUEST, EXT_CLK, EXT_QUAL, SAMPLE_VALID, ACTIVE, TRIGGERED;
    logic [1:0]  rs;
    logic [7:0]  mode;     // settings word of the current run
    int          mismatches, n_checks, nsamp, tail_n, gap, n_post;
    logic        trig_d;   // trigger flag as seen one cycle earlier
    // periods tried and the divider ratio each must give
    logic [31:0] per_t [6] = '{32'h5, 32'hc, 32'h16, 32'h10003, 32'h200c8, 32'h200fa};
    logic [31:0] rat_t [6] = '{32'h2, 32'h2, 32'h4, 32'h258, 32'h2625a00, 32'h2625a00};
    scsq_top scsq_top_i (.CLOCK(CLOCK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_CLK(EXT_CLK),
        .EXT_QUAL(EXT_QUAL), .PROBE(PROBE), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_DATA(SAMPLE_DATA), .ACTIVE(ACTIVE), .TRIGGERED(TRIGGERED));
    scsq_sut scsq_sut_i (.ext_clk(EXT_CLK), .ext_qual(EXT_QUAL), .probe(PROBE));
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    // ----------------------------------------
    // verdict, compare and bus tasks
    // ----------------------------------------
    task stop_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [6:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLOCK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= wd;
        AVS_WRITE     <= wr;
        AVS_READ      <= !wr;
        @(posedge CLOCK);
        while (AVS_WAITREQUEST !== 1'b0) begin
            n++;
            if (n > 50) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
            @(posedge CLOCK);
        end
        rd = AVS_READDATA;
        rs = AVS_RESPONSE;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask
    task rc(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // one recording: settings, lock probe while active, wait for the end
    task run(input logic [7:0] m, input logic [31:0] dly);
        int n;
        mode  = m;
        wmask = (m[5:4] == 2'h3) ? 32'hffffffff : ((32'h1 << (32'h4 << m[5:4])) - 32'h1);
        bus(1'b1, 7'h00, {24'h0, m});
        bus(1'b1, 7'h08, dly);
        nsamp = 0;
        n_post = 0;
        bus(1'b1, 7'h28, 32'h1);
        bus(1'b1, 7'h00, 32'h0);
        rc(7'h00, {24'h0, m});
        bus(1'b1, 7'h08, 32'h5);
        rc(7'h08, dly);
        n = 0;
        @(posedge CLOCK);
        while (ACTIVE !== 1'b0) begin
            n++;
            if (n > 40000) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
            @(posedge CLOCK);
        end
        if (m == 8'h3b) chk(tail_n, 32'd17);
        chk({31'h0, TRIGGERED}, 32'h1);
        rc(7'h24, nsamp);
        chk(n_post, dly);
        rc(7'h14, 32'he);
    endtask
    // ----------------------------------------
    // sample monitor
    // ----------------------------------------
    always @(posedge EXT_CLK) tail_n++;
    always @(posedge CLOCK) begin
        if (SAMPLE_VALID === 1'b1) begin
            if (mode[0] === 1'b0 && nsamp > 0) chk(gap, ratio);
            if (mode[0] === 1'b1) chk({31'h0, SAMPLE_DATA[0]}, {31'h0, mode[1]});
            if (mode[0] === 1'b1 && mode[3:2] != 2'h2)
                chk({31'h0, SAMPLE_DATA[1]}, {31'h0, mode[2]});
            chk(SAMPLE_DATA & ~wmask, 32'h0);
            if (mode[7:6] == 2'h1) chk({31'h0, SAMPLE_DATA[1]}, 32'h1);
            // samples after the trigger sample are the delay count
            if (trig_d === 1'b1) n_post++;
            nsamp++;
            gap    = 0;
            tail_n = 0;
        end
        trig_d = TRIGGERED;
        gap++;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        RSTN = 1'b0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 7'h0;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'hf;
        {mismatches, n_checks, nsamp, tail_n, gap, n_post} = '0;
        trig_d = 1'b0;
        mode = 8'h3a;
        ratio = 32'h2;
        wmask = 32'hffffffff;
        repeat (6) @(posedge CLOCK);
        RSTN <= 1'b1;
        rc(7'h00, `SCSQ_CTRL_RST);
        rc(7'h04, `SCSQ_PERIOD_RST);
        rc(7'h08, 32'h0);
        rc(7'h18, 32'h2);
        for (int i = 0; i < 4; i++) begin
            rc(7'h40 + 7'(4 * i), 32'h0);
            rc(7'h50 + 7'(4 * i), 32'h0);
        end
        bus(1'b0, 7'h30, 32'h0);
        chk({30'h0, rs}, 32'h2);
        bus(1'b1, 7'h0c, 32'h19);
        rc(7'h0c, 32'h13);
        bus(1'b1, 7'h0c, 32'h12);
        rc(7'h0c, 32'h12);
        // period entries, including out-of-range ends and an unreachable value
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 7'h04, per_t[i]);
            rc(7'h18, rat_t[i]);
        end
        rc(7'h1c, 32'h502f9000);
        rc(7'h20, 32'h9);
        bus(1'b1, 7'h04, 32'h16);
        ratio = 32'h4;
        run(8'h32, 32'h6);
        run(8'h3b, 32'ha);
        run(8'h29, 32'ha);
        run(8'h13, 32'ha);
        run(8'h05, 32'ha);
        // word D matches probe bit 1 high; record only samples that match it
        bus(1'b1, 7'h4c, 32'h2);
        bus(1'b1, 7'h5c, 32'h2);
        bus(1'b1, 7'h10, 32'h80);
        run(8'h7b, 32'h4);
        stop_test;
    end
endmodule
